// [rtl/pulse_acc_pkg.sv]
// constants for the pulse accumulator counter
package pulse_acc_pkg;
  localparam int count_width = 8;
  localparam int addr_width = 4;
  localparam int data_width = 8;
  localparam int gate_divide = 64;
  localparam logic [addr_width-1:0] addr_count = 4'h0;
  localparam logic [addr_width-1:0] addr_control = 4'h1;
  localparam logic [addr_width-1:0] addr_irq_enable = 4'h2;
  localparam logic [addr_width-1:0] addr_flags = 4'h3;
  localparam logic [addr_width-1:0] addr_flag_clear = 4'h4;
  localparam logic [addr_width-1:0] addr_pin_level = 4'h5;
  // control register fields
  localparam int ctl_enable_bit = 6;
  localparam int ctl_mode_bit = 5;
  localparam int ctl_edge_bit = 4;
  // flag layout, shared by flags, clear and enable registers
  localparam int flag_ovf_bit = 4;
  localparam int flag_edge_bit = 5;
  localparam logic [data_width-1:0] control_reset = 8'h00;
  localparam logic [data_width-1:0] irq_enable_reset = 8'h00;
  localparam logic [count_width-1:0] count_reset = 8'h00;
  localparam logic [count_width-1:0] count_max = 8'hff;
endpackage

// [rtl/pulse_accumulator_counter.sv]
// eight-bit pulse accumulator with event and gated-time modes
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Function
// - event mode counts each selected edge on the count input pin.
// - software may preset the counter any time; two's complement gives N.
// - from zero, overflow occurs on the 256th count and every 256 after.
// - gated mode counts once per 64 clocks while pin is active.
// - edge select also picks the inhibit level in gated mode.
// - counting resumes from held value on each new active pulse.
// - gated counter stopped outside active level; overflow before end counts.
// - gated mode raises overflow and trailing-edge conditions, each maskable.
// - overflow interrupt has priority over input edge interrupt.
// - software can read the pin level at any time.
// - edge interrupt gated by local enable; the global mask gates it only at irq_out.
// - edge flag readable as pending and clearable by software.
// - overflow flag set on ff to 00; cleared writing one to bit 4.
// - mode select 0 is event counting, 1 is gated accumulation.
// - edge select 0 falling, inhibit 0; 1 rising, inhibit 1.
// - with enable clear counter stops, flags hold but never newly set.
module pulse_accumulator_counter
  import pulse_acc_pkg::*;
#(
  parameter int divide = gate_divide
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [addr_width-1:0] addr_in,
  input wire logic [data_width-1:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [data_width-1:0] rdata_out,
  // pin and cpu mask
  input wire logic count_input_pin_in,
  input wire logic global_irq_mask_in,
  // interrupts
  output logic irq_out,
  output logic overflow_irq_out,
  output logic input_edge_irq_out
);

  logic [data_width-1:0] control_reg;
  logic [data_width-1:0] irq_enable_reg;
  logic [count_width-1:0] pulse_count_value_reg;
  logic count_overflow_flag_reg;
  logic input_edge_flag_reg;
  logic pin_prev_reg;
  logic [$clog2(divide)-1:0] prescale_reg;
  logic accumulator_enable;
  logic count_mode_select;
  logic edge_polarity_select;
  logic edge_seen;
  logic tick;
  logic count_step;
  logic pin_active;
  logic wr_count;
  logic wr_clear;

  assign accumulator_enable = control_reg[ctl_enable_bit];
  assign count_mode_select = control_reg[ctl_mode_bit];
  assign edge_polarity_select = control_reg[ctl_edge_bit];
  assign wr_count = write_in && addr_in == addr_count;
  assign wr_clear = write_in && addr_in == addr_flag_clear;

  // selected edge; in gated mode it is also the trailing edge of the gate
  assign edge_seen = edge_polarity_select ?
                     (count_input_pin_in && !pin_prev_reg) :
                     (!count_input_pin_in && pin_prev_reg);
  // active level is the level opposite the inhibit level
  assign pin_active = count_input_pin_in != edge_polarity_select;
  assign tick = prescale_reg == ($clog2(divide))'(divide - 1);

  always_comb begin
    if (!accumulator_enable) begin
      count_step = 1'b0;
    end else if (count_mode_select) begin
      count_step = tick && pin_active;
    end else begin
      count_step = edge_seen;
    end
  end

  // free-running divider, never reset by the pin so pulses do not restart it
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prescale_reg <= '0;
    end else if (tick) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= count_input_pin_in;
    end
  end

  // software write has priority over a count in the same cycle
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_count_value_reg <= count_reset;
    end else if (wr_count) begin
      pulse_count_value_reg <= wdata_in[count_width-1:0];
    end else if (count_step) begin
      pulse_count_value_reg <= pulse_count_value_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      control_reg <= control_reset;
      irq_enable_reg <= irq_enable_reset;
    end else if (write_in && addr_in == addr_control) begin
      control_reg <= wdata_in;
    end else if (write_in && addr_in == addr_irq_enable) begin
      irq_enable_reg <= wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_overflow_flag_reg <= 1'b0;
    end else if (count_step && !wr_count &&
                 pulse_count_value_reg == count_max) begin
      count_overflow_flag_reg <= 1'b1;
    end else if (wr_clear && wdata_in[flag_ovf_bit]) begin
      count_overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      input_edge_flag_reg <= 1'b0;
    end else if (accumulator_enable && edge_seen) begin
      input_edge_flag_reg <= 1'b1;
    end else if (wr_clear && wdata_in[flag_edge_bit]) begin
      input_edge_flag_reg <= 1'b0;
    end
  end

  // requests follow flags a cycle later; the cpu mask gates only irq_out
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overflow_irq_out <= 1'b0;
      input_edge_irq_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      overflow_irq_out <= count_overflow_flag_reg &&
                          irq_enable_reg[flag_ovf_bit] &&
                          accumulator_enable;
      // edge request masked while an overflow request stands
      input_edge_irq_out <= input_edge_flag_reg &&
                            irq_enable_reg[flag_edge_bit] &&
                            accumulator_enable &&
                            !(count_overflow_flag_reg &&
                              irq_enable_reg[flag_ovf_bit]);
      irq_out <= !global_irq_mask_in && accumulator_enable &&
                 ((count_overflow_flag_reg && irq_enable_reg[flag_ovf_bit])
                  || (input_edge_flag_reg &&
                      irq_enable_reg[flag_edge_bit]));
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= '0;
    end else if (read_in) begin
      case (addr_in)
        addr_count: rdata_out <= pulse_count_value_reg;
        addr_control: rdata_out <= control_reg;
        addr_irq_enable: rdata_out <= irq_enable_reg;
        addr_flags: begin
          rdata_out <= '0;
          rdata_out[flag_ovf_bit] <= count_overflow_flag_reg;
          rdata_out[flag_edge_bit] <= input_edge_flag_reg;
        end
        addr_pin_level: rdata_out <= {7'h00, count_input_pin_in};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // wrap, preset, gate, edge flag and request behaviour
  a_overflow_sets: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_step && !wr_count && pulse_count_value_reg == count_max
    |=> count_overflow_flag_reg && pulse_count_value_reg == 8'h00)
    else $error("overflow flag not set on wrap");
  a_counter_steps: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_step && !wr_count
    |=> pulse_count_value_reg == $past(pulse_count_value_reg) + 8'h01)
    else $error("counter did not step");
  a_preset_loads: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_count |=> pulse_count_value_reg == $past(wdata_in))
    else $error("preset not loaded");
  a_gate_inhibits: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_mode_select && !pin_active && !wr_count
    |=> $stable(pulse_count_value_reg))
    else $error("gated counter moved while inhibited");
  a_gated_rate: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_mode_select && count_step |-> tick)
    else $error("gated count off the divider tick");
  a_disabled_holds: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !accumulator_enable && !input_edge_flag_reg ##1 !wr_clear
    |-> !input_edge_flag_reg)
    else $error("edge flag set while disabled");
  a_edge_wins: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    accumulator_enable && edge_seen && wr_clear |=> input_edge_flag_reg)
    else $error("edge lost to clear");
  a_priority_order: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    overflow_irq_out |-> !input_edge_irq_out)
    else $error("edge request beside overflow request");
  a_request_follows: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    ##1 input_edge_irq_out |-> $past(input_edge_flag_reg))
    else $error("edge request without flag");
  a_mask_gates: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    $past(global_irq_mask_in) |-> !irq_out)
    else $error("interrupt passed global mask");

  // per-mode stepping; a preset write always owns its cycle
  a_event_edge_steps: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !count_mode_select && accumulator_enable && edge_seen && !wr_count
    |=> pulse_count_value_reg == $past(pulse_count_value_reg) + 8'h01)
    else $error("event edge not counted");
  a_event_holds: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !count_mode_select && !edge_seen && !wr_count
    |=> $stable(pulse_count_value_reg))
    else $error("event counter moved without an edge");
  a_gated_steps: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_mode_select && accumulator_enable && pin_active && tick && !wr_count
    |=> pulse_count_value_reg == $past(pulse_count_value_reg) + 8'h01)
    else $error("gated tick not counted");
  a_gated_off_tick: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_mode_select && !tick && !wr_count
    |=> $stable(pulse_count_value_reg))
    else $error("gated counter moved between ticks");
  a_disabled_stops: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !accumulator_enable && !wr_count |=> $stable(pulse_count_value_reg))
    else $error("disabled counter moved");

  // flag set and clear
  a_ovf_held_off: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !accumulator_enable && !count_overflow_flag_reg
    |=> !count_overflow_flag_reg)
    else $error("overflow flag set while disabled");
  a_ovf_only_wrap: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !count_overflow_flag_reg && pulse_count_value_reg != count_max
    |=> !count_overflow_flag_reg)
    else $error("overflow flag set without a wrap");
  a_ovf_clears: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_clear && wdata_in[flag_ovf_bit] && !count_step
    |=> !count_overflow_flag_reg)
    else $error("overflow flag not cleared");
  a_edge_sets: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    accumulator_enable && edge_seen |=> input_edge_flag_reg)
    else $error("edge flag not set");
  a_edge_clears: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_clear && wdata_in[flag_edge_bit] && !edge_seen
    |=> !input_edge_flag_reg)
    else $error("edge flag not cleared");

  // request outputs, register reads and the control write
  a_ovf_request_on: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_overflow_flag_reg && irq_enable_reg[flag_ovf_bit] &&
    accumulator_enable |=> overflow_irq_out)
    else $error("overflow request missing");
  a_ovf_request_off: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !count_overflow_flag_reg |=> !overflow_irq_out)
    else $error("overflow request without flag");
  a_edge_request_off: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !input_edge_flag_reg |=> !input_edge_irq_out)
    else $error("edge request after flag cleared");
  a_edge_masked: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_overflow_flag_reg && irq_enable_reg[flag_ovf_bit]
    |=> !input_edge_irq_out)
    else $error("edge request beside pending overflow");
  a_mask_open: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !global_irq_mask_in && accumulator_enable && input_edge_flag_reg &&
    irq_enable_reg[flag_edge_bit] |=> irq_out)
    else $error("unmasked edge request missing");
  a_count_read: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    read_in && addr_in == addr_count
    |=> rdata_out == $past(pulse_count_value_reg))
    else $error("count read wrong");
  a_pin_level_read: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    read_in && addr_in == addr_pin_level
    |=> rdata_out[0] == $past(count_input_pin_in) &&
        rdata_out[data_width-1:1] == '0)
    else $error("pin level read wrong");
  a_control_loads: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    write_in && addr_in == addr_control |=> control_reg == $past(wdata_in))
    else $error("control write lost");

  // main scenarios the bench is meant to reach
  c_event_wrap: cover property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !count_mode_select && count_step && pulse_count_value_reg == count_max);
  c_gated_count: cover property (@(posedge ref_clk_in)
    disable iff (!reset_n_in) count_mode_select && count_step);
  c_trailing_edge: cover property (@(posedge ref_clk_in)
    disable iff (!reset_n_in) count_mode_select && input_edge_irq_out);
  c_clear_collide: cover property (@(posedge ref_clk_in)
    disable iff (!reset_n_in) accumulator_enable && edge_seen && wr_clear);
  c_gated_overflow: cover property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    count_mode_select && count_step && pulse_count_value_reg == count_max);

endmodule

// [verif/pulse_accumulator_counter_tb.sv]
// self-checking bench for the pulse accumulator counter
`timescale 1ns/1ns
module pulse_accumulator_counter_tb;
  import pulse_acc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [addr_width-1:0] a_r = 4'h0;
  logic [data_width-1:0] d_r = 8'h00;
  logic wr_r = 1'b0;
  logic rd_r = 1'b0;
  logic [data_width-1:0] rdata;
  logic pin;
  logic mask = 1'b0;
  logic irq, ovf_irq, edge_irq;
  logic start = 1'b0;
  logic busy;
  logic [7:0] width = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic rd_pend = 1'b0;
  logic [7:0] q[$];
  logic [7:0] p, n;
  int errors = 0;
  int num_checks = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  // divider shortened to 4 so gated runs stay short
  pulse_accumulator_counter #(.divide(4)) dut (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .addr_in(a_r), .wdata_in(d_r),
    .write_in(wr_r), .read_in(rd_r), .rdata_out(rdata),
    .count_input_pin_in(pin), .global_irq_mask_in(mask),
    .irq_out(irq), .overflow_irq_out(ovf_irq),
    .input_edge_irq_out(edge_irq));
  pulse_source src (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .start_in(start), .width_in(width), .count_in(cnt), .pin_out(pin),
    .busy_out(busy));
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rd_pend) begin
      chk(rdata, q.pop_front());
    end
    rd_pend <= rd_r;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    a_r <= a;
    d_r <= d;
    wr_r <= 1'b1;
    @(posedge ref_clk_in);
    wr_r <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    a_r <= a;
    rd_r <= 1'b1;
    q.push_back(e);
    @(posedge ref_clk_in);
    rd_r <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic pulses(input logic [7:0] k, input logic [7:0] w);
    int i;
    @(posedge ref_clk_in);
    start <= 1'b1;
    cnt <= k;
    width <= w;
    @(posedge ref_clk_in);
    start <= 1'b0;
    for (i = 0; i < 3000 && (i < 2 || busy); i++) @(negedge ref_clk_in);
    if (busy) begin
      chk(8'h01, 8'h00);
      end_of_test();
    end
    repeat (4) @(posedge ref_clk_in);
  endtask
  initial begin
    void'($urandom(32'h9c9ce604));
    repeat (4) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h5, 8'h00);
    wr(4'h1, 8'h40);
    pulses(8'h03, 8'h03);
    rd(4'h0, 8'h03);
    rd(4'h3, 8'h20);
    wr(4'h0, 8'hfd);
    pulses(8'h03, 8'h03);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h30);
    wr(4'h2, 8'h30);
    repeat (2) @(posedge ref_clk_in);
    chk(irq, 8'h01);
    chk(ovf_irq, 8'h01);
    chk(edge_irq, 8'h00);
    mask <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    chk(irq, 8'h00);
    wr(4'h4, 8'h10);
    rd(4'h3, 8'h20);
    chk(edge_irq, 8'h01);
    wr(4'h4, 8'h20);
    rd(4'h3, 8'h00);
    chk(edge_irq, 8'h00);
    wr(4'h0, 8'h00);
    pulses(8'hff, 8'h02);
    rd(4'h0, 8'hff);
    rd(4'h3, 8'h20);
    pulses(8'h01, 8'h02);
    rd(4'h3, 8'h30);
    wr(4'h1, 8'h50);
    p = 8'($urandom_range(0, 250));
    n = 8'($urandom_range(1, 5));
    wr(4'h0, p);
    pulses(n, 8'h03);
    rd(4'h0, p + n);
    wr(4'h4, 8'h30);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h60);
    // pin high for 40 clocks gives 40 / 4 counts
    pulses(8'h01, 8'h28);
    rd(4'h0, 8'h0a);
    rd(4'h3, 8'h20);
    pulses(8'h01, 8'h14);
    rd(4'h0, 8'h0f);
    wr(4'h1, 8'h00);
    wr(4'h4, 8'h30);
    pulses(8'h02, 8'h03);
    rd(4'h0, 8'h0f);
    rd(4'h3, 8'h00);
    // preset fe, 20 active clocks: 5 ticks with one overflow inside the pulse
    wr(4'h1, 8'h60);
    wr(4'h0, 8'hfe);
    pulses(8'h01, 8'h14);
    rd(4'h3, 8'h30);
    chk(ovf_irq, 8'h01);
    chk(edge_irq, 8'h00);
    // 256 x 1 overflow + final 3 - preset fe = 5 counts of 4 clocks = 20
    rd(4'h0, 8'h03);
    end_of_test();
  end
endmodule

// [verif/pulse_source.sv]
// external pulse source driving the count input pin
`timescale 1ns/1ns
module pulse_source (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // command from the bench
  input wire logic start_in,
  input wire logic [7:0] width_in,
  input wire logic [7:0] count_in,
  // pin side
  output logic pin_out,
  output logic busy_out
);
  logic [7:0] width_reg;
  logic [7:0] timer_reg;
  logic [8:0] edges_reg;
  // each pulse is one rise and one fall, so both edge modes see it
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out <= 1'b0;
      busy_out <= 1'b0;
      edges_reg <= 9'h000;
      timer_reg <= 8'h00;
      width_reg <= 8'h00;
    end else if (start_in) begin
      edges_reg <= {count_in, 1'b0};
      width_reg <= width_in;
      timer_reg <= width_in;
      busy_out <= 1'b1;
    end else if (edges_reg != 9'h000) begin
      if (timer_reg <= 8'h01) begin
        pin_out <= ~pin_out;
        edges_reg <= edges_reg - 9'h001;
        timer_reg <= width_reg;
      end else begin
        timer_reg <= timer_reg - 8'h01;
      end
    end else begin
      busy_out <= 1'b0;
    end
  end
endmodule
